/* sfd_axis.sv */
// sfd_axis: device end; per control cycle slave position path with
// differential gear, output filter, speed clamp and torque pass-through
// assumes master position is sampled by the clock and settings come
// over the link from the controlling unit
//
// Notes on behaviour
// [RL1] output position is main plus auxiliary value
// [RL2] controller supplies aux as absolute position
// [RL3] aux at start latched as compensation origin
// [RL4] aux selection: 0 none, 1 link data
// [RL5] aux data at word offset in area
// [RL6] aux settings re-read and applied each cycle
// [RL7] rotation axis aux delta takes shortest route
// [RL8] controller keeps aux step under quarter range; sfd_ctrl passes any requested step on unchecked
// [RL9] controller wraps aux into rotation range
// [RL10] controller updates aux only after acknowledge
// [RL11] filter adds output value to remainder
// [RL12] emits remainder divided by constant plus one
// [RL13] emitted value subtracted, remainder carried on
// [RL14] constant 0 disables; else tenth of setting
// [RL15] filter constant re-read every cycle
// [RL16] per-cycle output clamped to maximum speed
// [RL17] torque data output while feeding is on
// [RL18] torque option always spans two words
// [RL19] filter division rounds away from zero to whole units
// [RL20] main value is master delta times gear
// [RL21] deceleration stop acts as immediate stop
`timescale 1ns/10ps
module sfd_axis
  import sfd_pkg::*;
#(
  parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic signed [POS_W-1:0] master_pos,
  output logic signed [POS_W-1:0] slave_step,
  output logic signed [POS_W-1:0] cmd_pos,
  output logic busy,
  output logic signed [15:0] trq_ff,
  output logic [15:0] trq_fwd_lim,
  output logic [15:0] trq_rev_lim,
  sfd_link_if.dev link
);
  localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLKS - 1);

  logic [CNT_W-1:0] cnt, next_cnt;
  logic tick, next_tick;
  sfd_state_e state, next_state;
  logic signed [POS_W-1:0] master_prev, next_master_prev;
  logic signed [POS_W-1:0] aux_prev, next_aux_prev;
  logic signed [POS_W-1:0] remain, next_remain;
  logic signed [POS_W-1:0] next_slave_step, next_cmd_pos;
  logic signed [15:0] next_trq_ff;
  logic [15:0] next_trq_fwd, next_trq_rev;
  logic stop_req;
  logic signed [POS_W-1:0] aux_now;

  // fetch a word of the link area, zero beyond the area
  function automatic logic [15:0] get_word(
      input logic [LINK_WORDS-1:0][WORD_W-1:0] w, input logic [3:0] i);
    get_word = (i < 4'(LINK_WORDS)) ? w[i[2:0]] : 16'h0;
  endfunction

  // divide and round away from zero to a whole unit
  function automatic logic signed [63:0] div_up(input logic signed [63:0] a,
                                                input logic signed [63:0] b);
    logic signed [63:0] q;
    q = a / b;
    if (a % b != 0) q = (a < 0) ? q - 64'sh1 : q + 64'sh1;
    div_up = q;
  endfunction

  // shortest signed distance inside a counter of span up+1
  function automatic logic signed [POS_W-1:0] short_delta(
      input logic signed [POS_W-1:0] d, input logic [POS_W-1:0] up);
    logic signed [33:0] span, dd;
    span = 34'(up) + 34'sh1;
    dd = 34'(d);
    if (dd > (span >>> 1)) dd = dd - span;
    else if (dd < -(span >>> 1)) dd = dd + span;
    short_delta = dd[POS_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control cycle divider; one-cycle tick per control cycle
  always_comb begin
    next_cnt = (cnt == CNT_LAST) ? '0 : CNT_W'(cnt + 1'b1);
    next_tick = (cnt == CNT_LAST);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-cycle position path; everything is evaluated only on the tick,
  // settings are taken live so changes act from the next cycle
  // a deceleration request is handled exactly like an immediate stop
  assign stop_req = link.decel_stop | link.imm_stop; // [RL21]
  assign aux_now = $signed({get_word(link.link_words,
                                     4'(link.aux_ofs) + 4'h1),
                            get_word(link.link_words,
                                     4'(link.aux_ofs))}); // [RL5] [RL6]

  always_comb begin
    logic signed [POS_W-1:0] mdelta, adelta, outv, step;
    logic signed [63:0] mainv, acc, emit;
    logic [POS_W:0] span;
    mdelta = '0;
    adelta = '0;
    outv = '0;
    step = '0;
    mainv = '0;
    acc = '0;
    emit = '0;
    span = '0;
    next_state = state;
    next_master_prev = master_prev;
    next_aux_prev = aux_prev;
    next_remain = remain;
    next_slave_step = slave_step;
    next_cmd_pos = cmd_pos;
    if (tick) begin
      next_master_prev = master_pos;
      next_slave_step = '0;
      case (state)
        SFD_IDLE: begin
          next_remain = '0;
          if (link.feed_cmd && !stop_req) begin
            next_state = SFD_RUN;
            next_aux_prev = aux_now; // origin is offset 0 [RL3]
          end
        end
        SFD_RUN: begin
          if (!link.feed_cmd || stop_req) begin
            next_state = SFD_IDLE; // no ramp, stop at once [RL21]
            next_remain = '0;
          end else begin
            // geared master movement [RL20]
            mdelta = master_pos - master_prev;
            if (link.gear_den == 16'h0) mainv = 64'(mdelta);
            else mainv = (64'(mdelta) * 64'(link.gear_num)) /
                         $signed({48'h0, link.gear_den});
            // auxiliary compensation as difference to last value
            if (link.aux_sel == AUX_SEL_LINK) begin // [RL4] [RL6]
              adelta = aux_now - aux_prev;
              if (link.rot_axis)
                adelta = short_delta(adelta, link.rot_upper); // [RL7]
            end
            next_aux_prev = aux_now;
            outv = POS_W'(mainv) + adelta; // [RL1]
            // averaging filter with carried remainder
            acc = 64'(remain) + 64'(outv); // [RL11]
            emit = div_up(acc * FILT_SCALE, // [RL12] [RL19]
                          64'(link.filt_const) + FILT_SCALE); // [RL14] [RL15]
            // clamp to maximum speed; clamped part stays in remainder
            if (emit > $signed({32'h0, link.max_speed}))
              emit = $signed({32'h0, link.max_speed}); // [RL16]
            else if (emit < -$signed({32'h0, link.max_speed}))
              emit = -$signed({32'h0, link.max_speed}); // [RL16]
            next_remain = POS_W'(acc - emit); // [RL13]
            step = POS_W'(emit);
            next_slave_step = step;
            next_cmd_pos = cmd_pos + step;
            // keep command position in the rotation counter
            if (link.rot_axis) begin
              span = 33'(link.rot_upper) + 33'h1;
              if (next_cmd_pos < 0)
                next_cmd_pos = POS_W'(33'(next_cmd_pos) + span);
              else if (next_cmd_pos > $signed({1'b0, link.rot_upper}))
                next_cmd_pos = POS_W'(33'(next_cmd_pos) - span);
            end
          end
        end
        default: next_state = SFD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // torque option words; two slots read whatever the selection
  always_comb begin
    logic [15:0] opt1, opt2;
    opt1 = get_word(link.link_words, 4'(link.trq_ofs)); // [RL18]
    opt2 = get_word(link.link_words, 4'(link.trq_ofs) + 4'h1); // [RL18]
    next_trq_ff = 16'sh0;
    next_trq_fwd = MAX_TORQUE;
    next_trq_rev = MAX_TORQUE;
    // leaving feed snaps back to zero feedforward and full limit
    if (state == SFD_RUN) begin // [RL17]
      case (link.trq_sel)
        TRQ_SEL_FF_LIM: begin
          next_trq_ff = opt1;
          next_trq_fwd = opt2;
          next_trq_rev = opt2;
        end
        TRQ_SEL_FF: next_trq_ff = opt1;
        TRQ_SEL_LIM: begin
          next_trq_fwd = opt2;
          next_trq_rev = opt2;
        end
        TRQ_SEL_FWD_REV: begin
          next_trq_fwd = opt1;
          next_trq_rev = opt2;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= SFD_IDLE;
      master_prev <= '0;
      aux_prev <= '0;
      remain <= '0;
      slave_step <= '0;
      cmd_pos <= '0;
      trq_ff <= 16'sh0;
      trq_fwd_lim <= MAX_TORQUE;
      trq_rev_lim <= MAX_TORQUE;
    end else begin
      state <= next_state;
      master_prev <= next_master_prev;
      aux_prev <= next_aux_prev;
      remain <= next_remain;
      slave_step <= next_slave_step;
      cmd_pos <= next_cmd_pos;
      trq_ff <= next_trq_ff;
      trq_fwd_lim <= next_trq_fwd;
      trq_rev_lim <= next_trq_rev;
    end
  end

  // acknowledge and busy follow the run state
  assign busy = (state == SFD_RUN);
  assign link.feed_ack = (state == SFD_RUN);
  assign link.cycle_tick = tick;
endmodule // sfd_axis

/* sfd_pkg.sv */
// sfd_pkg: shared constants for the synchronous feeding position path
// assumes both ends and the testbench import it whole
package sfd_pkg;
  // clock and control cycle
  localparam int CLK_MHZ = 50;
  localparam int CTRL_CYCLE_US = 1000;
  localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_US * CLK_MHZ;
  // data link output area
  localparam int LINK_WORDS = 8;
  localparam int WORD_W = 16;
  localparam int POS_W = 32;
  // setting ranges and defaults
  localparam logic [0:0] AUX_SEL_NONE = 1'h0;
  localparam logic [0:0] AUX_SEL_LINK = 1'h1;
  localparam logic [14:0] FILT_MAX = 15'h7fff;
  localparam logic [14:0] FILT_DEFAULT = 15'h0000;
  localparam int FILT_SCALE = 10;
  localparam logic [2:0] TRQ_SEL_NONE = 3'h0;
  localparam logic [2:0] TRQ_SEL_FF_LIM = 3'h1;
  localparam logic [2:0] TRQ_SEL_FF = 3'h2;
  localparam logic [2:0] TRQ_SEL_LIM = 3'h3;
  localparam logic [2:0] TRQ_SEL_FWD_REV = 3'h4;
  localparam logic [15:0] MAX_TORQUE = 16'h2710;
  // controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AUX_CFG = 8'h04;
  localparam logic [7:0] REG_FILT = 8'h08;
  localparam logic [7:0] REG_TRQ_CFG = 8'h0c;
  localparam logic [7:0] REG_GEAR_NUM = 8'h10;
  localparam logic [7:0] REG_GEAR_DEN = 8'h14;
  localparam logic [7:0] REG_ROT_UPPER = 8'h18;
  localparam logic [7:0] REG_MAX_SPEED = 8'h1c;
  localparam logic [7:0] REG_AUX_POS = 8'h20;
  localparam logic [7:0] REG_TRQ_DATA = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  // control register bits
  localparam int CTRL_FEED = 0;
  localparam int CTRL_DECEL = 1;
  localparam int CTRL_IMM = 2;
  localparam int CTRL_ROT = 3;
  typedef enum logic {SFD_IDLE, SFD_RUN} sfd_state_e;
endpackage

/* sfd_link_if.sv */
// sfd_link_if: synchronous data link between the controlling unit and
// the position path; one modport per end, no clocking block
`timescale 1ns/10ps
interface sfd_link_if
  import sfd_pkg::*;
  ();
  logic feed_cmd;
  logic decel_stop;
  logic imm_stop;
  logic rot_axis;
  logic aux_sel;
  logic [2:0] aux_ofs;
  logic [14:0] filt_const;
  logic [2:0] trq_sel;
  logic [2:0] trq_ofs;
  logic signed [15:0] gear_num;
  logic [15:0] gear_den;
  logic [POS_W-1:0] rot_upper;
  logic [POS_W-1:0] max_speed;
  logic [LINK_WORDS-1:0][WORD_W-1:0] link_words;
  logic feed_ack;
  logic cycle_tick;
  modport ctrl (
    output feed_cmd, decel_stop, imm_stop, rot_axis, aux_sel, aux_ofs,
    output filt_const, trq_sel, trq_ofs, gear_num, gear_den, rot_upper,
    output max_speed, link_words,
    input feed_ack, cycle_tick
  );
  modport dev (
    input feed_cmd, decel_stop, imm_stop, rot_axis, aux_sel, aux_ofs,
    input filt_const, trq_sel, trq_ofs, gear_num, gear_den, rot_upper,
    input max_speed, link_words,
    output feed_ack, cycle_tick
  );
endinterface // sfd_link_if

/* sfd_ctrl.sv */
// sfd_ctrl: controlling-unit end; software registers drive the link
// assumes a plain strobe port from software and the device on the link
`timescale 1ns/10ps
module sfd_ctrl
  import sfd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  sfd_link_if.ctrl link
);
  logic [3:0] ctrl, next_ctrl;
  logic aux_sel, next_aux_sel;
  logic [2:0] aux_ofs, next_aux_ofs;
  logic [14:0] filt, next_filt;
  logic [2:0] trq_sel, next_trq_sel;
  logic [2:0] trq_ofs, next_trq_ofs;
  logic signed [15:0] gnum, next_gnum;
  logic [15:0] gden, next_gden;
  logic [31:0] rot_up, next_rot_up;
  logic [31:0] maxspd, next_maxspd;
  logic [31:0] aux_req, next_aux_req;
  logic [31:0] trq_req, next_trq_req;
  logic [31:0] aux_live, next_aux_live;
  logic [LINK_WORDS-1:0][WORD_W-1:0] words, next_words;
  logic [31:0] next_rdata;

  // wrap a requested absolute value into the rotation counter range
  function automatic logic [31:0] wrap_rot(input logic [31:0] v,
                                           input logic [31:0] up);
    logic [32:0] span;
    span = {1'b0, up} + 33'h1;
    if ($signed(v) < 0) wrap_rot = 32'(33'(v) + span);
    else if (v > up) wrap_rot = 32'(33'(v) - span);
    else wrap_rot = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register writes, link area image and read data
  always_comb begin
    next_ctrl = ctrl;
    next_aux_sel = aux_sel;
    next_aux_ofs = aux_ofs;
    next_filt = filt;
    next_trq_sel = trq_sel;
    next_trq_ofs = trq_ofs;
    next_gnum = gnum;
    next_gden = gden;
    next_rot_up = rot_up;
    next_maxspd = maxspd;
    next_aux_req = aux_req;
    next_trq_req = trq_req;
    next_aux_live = aux_live;
    next_words = '0;
    next_rdata = 32'h0;
    if (wr) begin
      case (addr)
        REG_CTRL: next_ctrl = wdata[3:0];
        REG_AUX_CFG: begin
          next_aux_sel = wdata[0];
          next_aux_ofs = wdata[10:8];
        end
        REG_FILT: next_filt = wdata[14:0];
        REG_TRQ_CFG: begin
          next_trq_sel = wdata[2:0];
          next_trq_ofs = wdata[10:8];
        end
        REG_GEAR_NUM: next_gnum = wdata[15:0];
        REG_GEAR_DEN: next_gden = wdata[15:0];
        REG_ROT_UPPER: next_rot_up = wdata;
        REG_MAX_SPEED: next_maxspd = wdata;
        REG_AUX_POS: next_aux_req = wdata; // absolute value [RL2]
        REG_TRQ_DATA: next_trq_req = wdata;
        default: ;
      endcase
    end
    // aux data reaches the link only once the device has acknowledged
    if (link.feed_ack) begin
      next_aux_live = ctrl[CTRL_ROT] ? wrap_rot(aux_req, rot_up) // [RL9]
                                     : aux_req; // [RL10]
    end
    // two words each for aux position and torque data
    next_words[aux_ofs] = aux_live[15:0];
    next_words[3'(aux_ofs + 3'h1)] = aux_live[31:16];
    // selection zero claims no slots, so aux words at 0 and 1 stay visible
    if (trq_sel != TRQ_SEL_NONE) begin // [RL18]
      next_words[trq_ofs] = trq_req[15:0];
      next_words[3'(trq_ofs + 3'h1)] = trq_req[31:16];
    end
    if (rd) begin
      case (addr)
        REG_CTRL: next_rdata = {28'h0, ctrl};
        REG_AUX_CFG: next_rdata = {21'h0, aux_ofs, 7'h0, aux_sel};
        REG_FILT: next_rdata = {17'h0, filt};
        REG_TRQ_CFG: next_rdata = {21'h0, trq_ofs, 5'h0, trq_sel};
        REG_GEAR_NUM: next_rdata = {{16{gnum[15]}}, gnum};
        REG_GEAR_DEN: next_rdata = {16'h0, gden};
        REG_ROT_UPPER: next_rdata = rot_up;
        REG_MAX_SPEED: next_rdata = maxspd;
        REG_AUX_POS: next_rdata = aux_req;
        REG_TRQ_DATA: next_rdata = trq_req;
        REG_STATUS: next_rdata = {31'h0, link.feed_ack};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl <= 4'h0;
      aux_sel <= AUX_SEL_NONE;
      aux_ofs <= 3'h0;
      filt <= FILT_DEFAULT;
      trq_sel <= TRQ_SEL_NONE;
      trq_ofs <= 3'h0;
      gnum <= 16'sh0;
      gden <= 16'h0;
      rot_up <= 32'h0;
      maxspd <= 32'h7fffffff;
      aux_req <= 32'h0;
      trq_req <= 32'h0;
      aux_live <= 32'h0;
      words <= '0;
      rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      aux_sel <= next_aux_sel;
      aux_ofs <= next_aux_ofs;
      filt <= next_filt;
      trq_sel <= next_trq_sel;
      trq_ofs <= next_trq_ofs;
      gnum <= next_gnum;
      gden <= next_gden;
      rot_up <= next_rot_up;
      maxspd <= next_maxspd;
      aux_req <= next_aux_req;
      trq_req <= next_trq_req;
      aux_live <= next_aux_live;
      words <= next_words;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link drive straight from registers
  assign link.feed_cmd = ctrl[CTRL_FEED];
  assign link.decel_stop = ctrl[CTRL_DECEL];
  assign link.imm_stop = ctrl[CTRL_IMM];
  assign link.rot_axis = ctrl[CTRL_ROT];
  assign link.aux_sel = aux_sel;
  assign link.aux_ofs = aux_ofs;
  assign link.filt_const = filt;
  assign link.trq_sel = trq_sel;
  assign link.trq_ofs = trq_ofs;
  assign link.gear_num = gnum;
  assign link.gear_den = gden;
  assign link.rot_upper = rot_up;
  assign link.max_speed = maxspd;
  assign link.link_words = words;
endmodule // sfd_ctrl

/* sfd_chk.sv */
// sfd_chk: concurrent checks on the link between the two ends
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/10ps
module sfd_chk
  import sfd_pkg::*;
#(
  parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic feed_cmd,
  input wire logic decel_stop,
  input wire logic imm_stop,
  input wire logic feed_ack,
  input wire logic cycle_tick
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////
  // clocks since the last tick; the first period after reset is only
  // bounded, since the divider phase at release is a design choice
  logic [31:0] gap;
  logic [31:0] next_gap;
  logic seen;
  logic next_seen;
  always_comb begin
    next_gap = cycle_tick ? 32'h0 : gap + 32'h1;
    next_seen = seen | cycle_tick;
    if (srst) begin
      next_gap = 32'h0;
      next_seen = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    gap <= next_gap;
    seen <= next_seen;
  end

  ////////////////////////////////////////
  // control cycle pacing and run state on the link
  a_tick_pulse: assert property (cycle_tick |=> !cycle_tick)
    else $error("control tick wider than one clock");
  a_tick_period: assert property (
    cycle_tick && seen |-> gap == 32'(CYCLE_CLKS - 1))
    else $error("control tick period wrong");
  a_tick_gap: assert property (gap <= 32'(CYCLE_CLKS))
    else $error("control tick missing");
  a_ack_on_tick: assert property (
    $changed(feed_ack) |-> $past(cycle_tick))
    else $error("acknowledge moved between ticks");
  a_start_run: assert property (
    cycle_tick && feed_cmd && !decel_stop && !imm_stop |=> feed_ack)
    else $error("feeding did not start at tick");
  a_ack_cause: assert property (
    $rose(feed_ack) |-> $past(feed_cmd) && !$past(decel_stop) &&
      !$past(imm_stop))
    else $error("acknowledge rose without a start");
  a_start_refused: assert property (
    cycle_tick && !feed_ack && (decel_stop || imm_stop) |=> !feed_ack)
    else $error("start taken while a stop was held");
  a_decel_stops: assert property (
    cycle_tick && feed_ack && decel_stop |=> !feed_ack)
    else $error("deceleration stop did not stop at once");
  a_imm_stops: assert property (
    cycle_tick && imm_stop |=> !feed_ack ##1 !feed_ack)
    else $error("immediate stop did not stop");
  a_drop_stops: assert property (cycle_tick && !feed_cmd |=> !feed_ack)
    else $error("feeding kept running after the flag dropped");
  c_start: cover property (cycle_tick && feed_cmd && !feed_ack);
  c_decel: cover property (cycle_tick && feed_ack && decel_stop);
  c_refused: cover property (
    cycle_tick && !feed_ack && feed_cmd && decel_stop);
endmodule // sfd_chk

/* testbench.sv */
// testbench: controller and axis joined by the link, driven from the
// register port and the master position input; checks step values
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module testbench
  import sfd_pkg::*;
;
  localparam int CYC = 20;
  logic clock, srst, wr, rd, busy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic signed [POS_W-1:0] master_pos, slave_step, cmd_pos, d, prev, e;
  logic signed [15:0] trq_ff;
  logic [15:0] trq_fwd_lim, trq_rev_lim, e_ff, e_fwd, e_rev;
  int failures = 0;
  int comparisons = 0;
  integer seed = 32'ha40a;
  logic signed [POS_W-1:0] exp_q[$];
  logic tick_d = 1'b0;
  // expected command position; rot_lim nonzero once the axis rotates
  logic signed [POS_W-1:0] pos_exp = '0;
  logic signed [POS_W-1:0] rot_lim = '0;

  sfd_link_if link_bus();
  sfd_ctrl sfd_ctrl_i(.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link_bus));
  sfd_axis #(.CYCLE_CLKS(CYC)) sfd_axis_i(.clock(clock), .srst(srst),
    .master_pos(master_pos), .slave_step(slave_step), .cmd_pos(cmd_pos),
    .busy(busy), .trq_ff(trq_ff), .trq_fwd_lim(trq_fwd_lim),
    .trq_rev_lim(trq_rev_lim), .link(link_bus));
  sfd_chk #(.CYCLE_CLKS(CYC)) sfd_chk_i(.clock(clock), .srst(srst),
    .feed_cmd(link_bus.feed_cmd), .decel_stop(link_bus.decel_stop),
    .imm_stop(link_bus.imm_stop), .feed_ack(link_bus.feed_ack),
    .cycle_tick(link_bus.cycle_tick));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////
  // step lands on the tick edge, so it is read one edge later
  always @(posedge clock) begin
    if (tick_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(slave_step, e)
      // command position sums the steps, kept inside one turn if rotating
      pos_exp = pos_exp + e;
      if (rot_lim != 0 && pos_exp > rot_lim) pos_exp = pos_exp - rot_lim - 1;
      `CHK(cmd_pos, pos_exp)
      `CHK(busy, 1'b1)
    end
    tick_d <= link_bus.cycle_tick;
  end

  task automatic end_sim;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    `CHK(rdata, v)
  endtask

  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!link_bus.cycle_tick && n < 100);
    if (!link_bus.cycle_tick) begin
      failures++;
      end_sim();
    end
  endtask

  // note the step due at this tick, then move the master for the next
  task automatic tick(input logic signed [POS_W-1:0] dm,
                      input logic signed [POS_W-1:0] ex);
    wait_tick();
    exp_q.push_back(ex);
    master_pos <= master_pos + dm;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    master_pos = 32'h0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rd_reg(REG_FILT, 32'h0);
    rd_reg(REG_AUX_CFG, 32'h0);
    // filter walk at setting 5, then mid-run change of gear and filter
    wr_reg(REG_GEAR_NUM, 32'h1);
    wr_reg(REG_FILT, 32'h5);
    wait_tick();
    wr_reg(REG_CTRL, 32'h1);
    tick(10, 0);
    tick(10, 7);
    tick(10, 9);
    tick(10, 10);
    wr_reg(REG_GEAR_NUM, 32'hfffffffe);
    wr_reg(REG_GEAR_DEN, 32'h1);
    wr_reg(REG_FILT, 32'h0);
    tick(10, -16);
    tick(0, -20);
    // speed clamp keeps the excess in the remainder
    wr_reg(REG_MAX_SPEED, 32'hf);
    wr_reg(REG_GEAR_NUM, 32'h3);
    tick(10, 0);
    tick(10, 15);
    tick(0, 15);
    tick(0, 15);
    tick(0, 15);
    // random master moves, zero denominator means ratio one
    wr_reg(REG_MAX_SPEED, 32'h7fffffff);
    wr_reg(REG_GEAR_NUM, 32'h1);
    wr_reg(REG_GEAR_DEN, 32'h0);
    prev = 0;
    for (int i = 0; i < 8; i++) begin
      d = 32'($random(seed) % 101);
      tick(d, prev);
      prev = d;
    end
    tick(0, prev);
    wr_reg(REG_CTRL, 32'h0);
    wait_tick();
    // auxiliary input at word offset 3, origin latched at start
    wr_reg(REG_GEAR_NUM, 32'h0);
    wr_reg(REG_GEAR_DEN, 32'h1);
    wr_reg(REG_AUX_CFG, 32'h0301);
    wr_reg(REG_CTRL, 32'h1);
    tick(0, 0);
    wr_reg(REG_AUX_POS, 32'd800);
    tick(0, 800);
    wr_reg(REG_AUX_POS, 32'd1100);
    tick(0, 300);
    tick(0, 0);
    // torque option words 0 and 1, every selection while running
    wr_reg(REG_TRQ_DATA, 32'h0200_0100);
    for (int s = 0; s < 5; s++) begin
      wr_reg(REG_TRQ_CFG, 32'(s));
      repeat (4) @(posedge clock);
      e_ff = (s == 1 || s == 2) ? 16'h0100 : 16'h0000;
      e_fwd = (s == 1 || s == 3) ? 16'h0200 : (s == 4 ? 16'h0100 : MAX_TORQUE);
      e_rev = (s == 1 || s == 3 || s == 4) ? 16'h0200 : MAX_TORQUE;
      `CHK(trq_ff, e_ff)
      `CHK(trq_fwd_lim, e_fwd)
      `CHK(trq_rev_lim, e_rev)
    end
    wr_reg(REG_CTRL, 32'h0);
    wait_tick();
    repeat (3) @(posedge clock);
    `CHK(trq_ff, 16'h0000)
    `CHK(trq_rev_lim, MAX_TORQUE)
    `CHK(trq_fwd_lim, MAX_TORQUE)
    rd_reg(REG_STATUS, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    tick(0, 0);
    wr_reg(REG_AUX_POS, 32'd1300);
    tick(0, 200);
    // stops: deceleration acts at once, starts refused while held
    wr_reg(REG_CTRL, 32'h3);
    wait_tick();
    wait_tick();
    rd_reg(REG_STATUS, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    wait_tick();
    rd_reg(REG_STATUS, 32'h1);
    wr_reg(REG_CTRL, 32'h5);
    wait_tick();
    rd_reg(REG_STATUS, 32'h0);
    wr_reg(REG_CTRL, 32'h0);
    // unmapped address reads zero and ignores writes
    wr_reg(8'h3c, 32'h5a5a5a5a);
    rd_reg(8'h3c, 32'h0);
    rd_reg(REG_AUX_CFG, 32'h0301);
    // rotation axis with aux at word 0 and no torque option; each step
    // stays under a quarter turn, the last request runs past the limit
    wr_reg(REG_TRQ_CFG, 32'h0);
    wr_reg(REG_AUX_CFG, 32'h0001);
    wr_reg(REG_ROT_UPPER, 32'd3599);
    rot_lim = 32'd3599;
    wr_reg(REG_CTRL, 32'h9);
    tick(0, 0);
    wr_reg(REG_AUX_POS, 32'd2100);
    tick(0, 800);
    wr_reg(REG_AUX_POS, 32'd2900);
    tick(0, 800);
    wr_reg(REG_AUX_POS, 32'd3500);
    tick(0, 600);
    wr_reg(REG_AUX_POS, 32'd4300);
    tick(0, 800);
    tick(0, 0);
    wr_reg(REG_CTRL, 32'h0);
    wait_tick();
    end_sim();
  end
endmodule // testbench
